// >>> design/pdml_entry_delay.v
/*
  Entry delay for a newly written power-down select code.
  Assumes the load pulse and code come from logic on the same clock.
*/
`timescale 1ns/10ps
`include "pdml_map.vh"

module pdml_entry_delay #(
  parameter [3:0] DELAY = `PDML_ENTRY_CYC
) (
  input wire ref_clk,
  input wire rst_n,
  input wire load,
  input wire [5:0] code,
  output reg [5:0] code_eff
);

  reg [3:0] cnt_q;
  reg [5:0] pend_q;

  // =====================================================================
  // Counter
  // A fresh write restarts the count so the last code written wins.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      pend_q <= `PDML_PDS_NONE;
      code_eff <= `PDML_PDS_NONE;
    end else if (load) begin
      // The mode register behind this stage takes one more cycle, so the
      // count loads one short to land the new mode on the last cycle.
      cnt_q <= DELAY - 4'h1;
      pend_q <= code;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1) begin
        code_eff <= pend_q;
      end
    end
  end

endmodule

// >>> design/pdml_sync2.v
/*
  Two-flop synchroniser for a level from outside the clock domain.
  Assumes a slowly changing level input.
*/
`timescale 1ns/10ps

module pdml_sync2 (
  input wire ref_clk,
  input wire rst_n,
  input wire d,
  output reg q
);

  reg meta_q;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// >>> design/pdml_top.v
/*
  Power-down mode logic: select field decode, light sleep clock gating
  and wake-up, deep clock halt and PLL input stop modes, emulator mask
  and execution-command blocking, PLL relock wait after reset.
  A mode is entered only when the effective code changes, so writing the
  same code again does not start a second sleep.
  Assumes a plain register port on ref_clk, interrupt and emulator
  levels from outside the domain, and that clock gates themselves sit
  outside this block and obey the enable outputs.
*/
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "pdml_map.vh"

module pdml_top #(
  parameter integer LOCK_CYC = `PDML_LOCK_US * `PDML_CLK_MHZ
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [15:0] int_req,
  input wire emu_present,
  input wire emu_reset,
  input wire emu_exec_req,
  input wire emu_pc_write,
  output wire cpu_clk_en,
  output wire int_logic_clk_en,
  output wire dma_clk_en,
  output wire pll_out_en,
  output wire ref_clk_gate_en,
  output wire ext_clk_pass,
  output wire io_hold,
  output reg isr_start,
  output reg resume_pulse,
  output reg emu_exec_ack,
  output reg emu_pc_write_ok,
  output wire cpu_run_ok,
  output wire [1:0] pd_state
);

  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_LIGHT = 2'h1;
  localparam [1:0] ST_HALT = 2'h2;
  localparam [1:0] ST_PLLSTOP = 2'h3;

  // =====================================================================
  // Synchronise outside levels
  wire [15:0] int_s;
  wire emu_present_s;
  wire emu_reset_s;
  wire emu_exec_s;
  wire emu_pcw_s;

  // Requests arrive from other domains, so each bit passes two flops; a
  // wake is therefore seen two cycles after the level appears.
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_int_sync
      pdml_sync2 u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .d(int_req[gi]),
        .q(int_s[gi])
      );
    end
  endgenerate

  pdml_sync2 u_sync_ep (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d(emu_present),
    .q(emu_present_s)
  );
  pdml_sync2 u_sync_er (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d(emu_reset),
    .q(emu_reset_s)
  );
  pdml_sync2 u_sync_ex (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d(emu_exec_req),
    .q(emu_exec_s)
  );
  pdml_sync2 u_sync_pw (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d(emu_pc_write),
    .q(emu_pcw_s)
  );

  // =====================================================================
  // Registers
  reg [31:0] csw_q;
  reg [31:0] ier_q;
  wire csw_wr = reg_wr && (reg_addr == `PDML_OFS_CSW);
  wire global_int_enable = csw_q[`PDML_GIE_BIT];
  wire nonmaskable_int_enable = ier_q[`PDML_NONMASKABLE_INT_ENABLE_BIT];
  wire [5:0] pds_wr = reg_wdata[`PDML_PDS_HI:`PDML_PDS_LO];

  // Whole field latched at once from one write; bit 15 is stored as
  // written so software reads back what it wrote.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      csw_q <= `PDML_CSW_RST;
      ier_q <= `PDML_IER_RST;
    end else if (reg_wr) begin
      if (reg_addr == `PDML_OFS_CSW) begin
        csw_q <= reg_wdata & `PDML_CSW_WMASK;
      end
      if (reg_addr == `PDML_OFS_IER) begin
        ier_q <= reg_wdata;
      end
    end
  end

  // =====================================================================
  // Entry delay
  // The delay stage and the mode register together give the nine cycles
  // between the write and the new mode.
  wire [5:0] pds_eff;
  pdml_entry_delay #(
    .DELAY(`PDML_ENTRY_CYC)
  ) u_entry (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(csw_wr),
    .code(pds_wr),
    .code_eff(pds_eff)
  );

  // =====================================================================
  // Emulator mask, held until emulator reset or cable removal
  // A code that takes effect while masked is dropped, not deferred, so
  // removing the cable never starts a sleep on its own.
  reg emu_mask_q;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      emu_mask_q <= 1'b0;
    end else if (emu_reset_s || !emu_present_s) begin
      emu_mask_q <= 1'b0;
    end else begin
      emu_mask_q <= 1'b1;
    end
  end

  // =====================================================================
  // Mode state machine
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg wake_any_q;
  reg wake_any_d;
  reg [5:0] last_eff_q;
  wire new_eff = (pds_eff != last_eff_q);
  wire int_en_hit = |(int_s & ier_q[15:0]);
  wire int_any_hit = |int_s;
  reg wake;
  reg wake_enabled;

  // An enabled request is tested first so wake_enabled is always set
  // when both wake paths apply at once.
  always @* begin
    st_d = st_q;
    wake_any_d = wake_any_q;
    wake = 1'b0;
    wake_enabled = 1'b0;
    case (st_q)
      ST_RUN: begin
        if (new_eff && !emu_mask_q) begin
          case (pds_eff)
            `PDML_PDS_LS_EN: begin
              st_d = ST_LIGHT;
              wake_any_d = 1'b0;
            end
            `PDML_PDS_LS_ANY: begin
              st_d = ST_LIGHT;
              wake_any_d = 1'b1;
            end
            `PDML_PDS_HALT: st_d = ST_HALT;
            `PDML_PDS_PLLSTOP: st_d = ST_PLLSTOP;
            default: st_d = ST_RUN;
          endcase
        end
      end
      ST_LIGHT: begin
        if (int_en_hit) begin
          wake = 1'b1;
          wake_enabled = 1'b1;
          st_d = ST_RUN;
        end else if (wake_any_q && int_any_hit) begin
          wake = 1'b1;
          st_d = ST_RUN;
        end
      end
      // Deep modes ignore every interrupt; only rst_n leaves them.
      ST_HALT: st_d = ST_HALT;
      ST_PLLSTOP: st_d = ST_PLLSTOP;
      default: st_d = ST_RUN;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_RUN;
      wake_any_q <= 1'b0;
      last_eff_q <= `PDML_PDS_NONE;
      isr_start <= 1'b0;
      resume_pulse <= 1'b0;
    end else begin
      st_q <= st_d;
      wake_any_q <= wake_any_d;
      last_eff_q <= pds_eff;
      isr_start <= wake && wake_enabled && global_int_enable && nonmaskable_int_enable;
      resume_pulse <= wake;
    end
  end

  // =====================================================================
  // PLL relock wait after reset; a relock is always assumed since the
  // block cannot tell after reset which mode was left.
  reg [31:0] lock_cnt_q;
  wire locked = (lock_cnt_q == 32'h0000_0000);
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_q <= 32'hFFFF_FFFF;
    end else if (lock_cnt_q == 32'hFFFF_FFFF) begin
      lock_cnt_q <= LOCK_CYC[31:0];
    end else if (!locked) begin
      lock_cnt_q <= lock_cnt_q - 32'h0000_0001;
    end
  end

  // =====================================================================
  // Clock enables, one row per mode
  reg cpu_row;
  reg core_row;
  reg pll_row;
  reg ref_row;
  wire deep = (st_q == ST_HALT) || (st_q == ST_PLLSTOP);

  always @* begin
    cpu_row = 1'b0;
    core_row = 1'b1;
    pll_row = 1'b1;
    ref_row = 1'b1;
    case (st_q)
      ST_RUN: begin
        cpu_row = 1'b1;
      end
      ST_LIGHT: begin
        // Only the CPU boundary is gated; interrupt logic and DMA run on,
        // which is what lets a request end the sleep at all.
        cpu_row = 1'b0;
      end
      ST_HALT: begin
        core_row = 1'b0;
        pll_row = 1'b0;
      end
      ST_PLLSTOP: begin
        core_row = 1'b0;
        ref_row = 1'b0;
      end
      default: begin
        cpu_row = 1'b0;
      end
    endcase
  end

  // The CPU also waits out the relock count after every reset.
  assign cpu_clk_en = cpu_row && locked;
  assign int_logic_clk_en = core_row;
  assign dma_clk_en = core_row;
  assign pll_out_en = pll_row;
  assign ref_clk_gate_en = ref_row;
  assign ext_clk_pass = 1'b1;
  // Registers here are never cleared on entry, so contents survive.
  assign io_hold = deep;
  assign cpu_run_ok = cpu_clk_en;
  assign pd_state = st_q;

  // =====================================================================
  // Emulator commands spin idle in deep modes
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      emu_exec_ack <= 1'b0;
      emu_pc_write_ok <= 1'b0;
    end else begin
      emu_exec_ack <= emu_exec_s && !deep;
      emu_pc_write_ok <= emu_pcw_s && !deep;
    end
  end

  // =====================================================================
  // Read port
  // Read data stand only in the cycle after the strobe and are zero
  // otherwise, so a stale word is never taken for a fresh one.
  localparam integer STAT_W = 5;
  wire [STAT_W-1:0] stat_bits = {emu_mask_q, locked, wake_any_q, st_q};
  wire [31:0] stat_word = {{(32 - STAT_W){1'b0}}, stat_bits};

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `PDML_OFS_CSW: reg_rdata <= csw_q;
        `PDML_OFS_IER: reg_rdata <= ier_q;
        `PDML_OFS_STAT: reg_rdata <= stat_word;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// >>> pkg/pdml_map.vh
/*
  Constants for the power-down mode logic: register offsets, the select
  field layout, mode codes, reset values and timing counts.
  Assumes it is included by bare name from files under design/.
*/
`ifndef PDML_MAP_VH
`define PDML_MAP_VH

// =====================================================================
// Register map (word offsets on the plain register port)
`define PDML_ADDR_W 4
`define PDML_OFS_CSW 4'h0
`define PDML_OFS_IER 4'h1
`define PDML_OFS_STAT 4'h2

// =====================================================================
// Control status word fields and the IER non-maskable enable bit
`define PDML_PDS_HI 15
`define PDML_PDS_LO 10
`define PDML_GIE_BIT 0
`define PDML_NONMASKABLE_INT_ENABLE_BIT 1
`define PDML_CSW_RST 32'h0000_0000
`define PDML_IER_RST 32'h0000_0000
`define PDML_CSW_WMASK 32'h0000_FC01

// =====================================================================
// Select codes
`define PDML_PDS_NONE 6'h00
`define PDML_PDS_LS_EN 6'h09
`define PDML_PDS_LS_ANY 6'h11
`define PDML_PDS_HALT 6'h1A
`define PDML_PDS_PLLSTOP 6'h1C

// =====================================================================
// Timing
`define PDML_ENTRY_CYC 4'h9
`define PDML_LOCK_US 75
`define PDML_CLK_MHZ 200

`endif

// >>> test/pdml_partner.sv
/*
  Model of the interrupt sources beside the CPU core.
  Assumes the bench names a line and pulses int_go for one cycle.
*/
`timescale 1ns/10ps
module pdml_partner (
  input wire ref_clk,
  input wire rst_n,
  input wire [3:0] int_line,
  input wire int_go,
  input wire int_clr,
  input wire resume_pulse,
  output reg [15:0] int_req
);
  // A request is a held level, so a slow synchroniser cannot miss it;
  // it drops once any wake has been taken (resume_pulse) or when int_clr is pulsed.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_req <= 16'h0000;
    end else if (resume_pulse || int_clr) begin
      int_req <= 16'h0000;
    end else if (int_go) begin
      int_req <= int_req | (16'h0001 << int_line);
    end
  end
endmodule

// >>> test/pdml_properties.sv
/*
  Checker for pdml_top: clock enables per mode, entry delay, wake
  behaviour, emulator blocking and the relock wait after reset.
  Assumes it is bound onto pdml_top and sees only its ports.
*/
`timescale 1ns/10ps
module pdml_properties #(
  parameter integer LOCK_CYC = 8
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire emu_present,
  input wire cpu_clk_en,
  input wire int_logic_clk_en,
  input wire dma_clk_en,
  input wire pll_out_en,
  input wire ref_clk_gate_en,
  input wire ext_clk_pass,
  input wire io_hold,
  input wire isr_start,
  input wire resume_pulse,
  input wire emu_exec_ack,
  input wire emu_pc_write_ok,
  input wire [1:0] pd_state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // =====================================================================
  // Cycles since reset release, saturating so it never wraps back.
  reg [15:0] lock_cnt_q;
  wire [15:0] lock_cnt_d;
  assign lock_cnt_d = (&lock_cnt_q) ? lock_cnt_q : lock_cnt_q + 16'h0001;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_q <= 16'h0000;
    end else begin
      lock_cnt_q <= lock_cnt_d;
    end
  end

  // =====================================================================
  // Properties.
  a_lock_wait: assert property (
    lock_cnt_q < LOCK_CYC |-> !cpu_clk_en) else $error("cpu clock early");
  a_light_gates: assert property (
    pd_state == 2'h1 |-> !cpu_clk_en && int_logic_clk_en && dma_clk_en)
    else $error("light sleep enables wrong");
  a_halt_stops: assert property (
    pd_state == 2'h2 |-> !pll_out_en && io_hold) else $error("halt wrong");
  a_pll_stop: assert property (
    pd_state == 2'h3 |-> !ref_clk_gate_en && io_hold)
    else $error("pll stop wrong");
  a_ext_clk_pass: assert property (
    ext_clk_pass) else $error("external clock gated");
  a_deep_no_wake: assert property (
    pd_state[1] |=> pd_state == $past(pd_state)) else $error("deep left");
  a_deep_emu_block: assert property (
    pd_state[1] && $past(pd_state[1]) |-> !emu_exec_ack && !emu_pc_write_ok)
    else $error("emulator command passed in deep mode");
  a_entry_delay: assert property (
    reg_wr && reg_addr == 4'h0 && reg_wdata[15:10] == 6'h1A &&
    !emu_present && pd_state == 2'h0 |-> ##[1:10] pd_state == 2'h2)
    else $error("halt not entered in time");
  a_resume_src: assert property (
    resume_pulse |-> $past(pd_state) == 2'h1 || $past(pd_state, 2) == 2'h1)
    else $error("resume without light sleep");
  a_isr_wake: assert property (
    isr_start |-> resume_pulse) else $error("service without wake");
endmodule

bind pdml_top pdml_properties #(.LOCK_CYC(LOCK_CYC)) u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .emu_present(emu_present),
  .cpu_clk_en(cpu_clk_en), .int_logic_clk_en(int_logic_clk_en),
  .dma_clk_en(dma_clk_en), .pll_out_en(pll_out_en),
  .ref_clk_gate_en(ref_clk_gate_en), .ext_clk_pass(ext_clk_pass),
  .io_hold(io_hold), .isr_start(isr_start), .resume_pulse(resume_pulse),
  .emu_exec_ack(emu_exec_ack), .emu_pc_write_ok(emu_pc_write_ok),
  .pd_state(pd_state));

// >>> test/power_down_mode_logic_tb_top.sv
/*
  Self-checking bench for pdml_top with the interrupt source model.
  Assumes the map header and a shortened relock count.
*/
`timescale 1ns/10ps
`include "pdml_map.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module power_down_mode_logic_tb_top;
  localparam integer LOCK = 8;
  reg ref_clk, rst_n, reg_wr, reg_rd, int_go, int_clr;
  reg emu_present, emu_reset, emu_exec_req, emu_pc_write;
  reg [3:0] reg_addr, int_line;
  reg [31:0] reg_wdata, seed, rd_d;
  reg [15:0] int_enable_reg;
  wire [31:0] reg_rdata;
  wire [15:0] int_req;
  wire [1:0] pd_state;
  wire cpu_clk_en, ilc_en, dma_en, pll_en, ref_en, ext_p, io_hold;
  wire isr_start, resume_pulse, exec_ack, pcw_ok, run_ok;
  integer num_errors, cmp_count, cyc, i, k, n;
  reg [5:0] code_t [0:3];
  reg [1:0] isr_t [0:2];

  pdml_top #(.LOCK_CYC(LOCK)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_req(int_req),
    .emu_present(emu_present), .emu_reset(emu_reset),
    .emu_exec_req(emu_exec_req), .emu_pc_write(emu_pc_write),
    .cpu_clk_en(cpu_clk_en), .int_logic_clk_en(ilc_en),
    .dma_clk_en(dma_en), .pll_out_en(pll_en), .ref_clk_gate_en(ref_en),
    .ext_clk_pass(ext_p), .io_hold(io_hold), .isr_start(isr_start),
    .resume_pulse(resume_pulse), .emu_exec_ack(exec_ack),
    .emu_pc_write_ok(pcw_ok), .cpu_run_ok(run_ok), .pd_state(pd_state));
  pdml_partner u_partner (.ref_clk(ref_clk), .rst_n(rst_n),
    .int_line(int_line), .int_go(int_go), .int_clr(int_clr),
    .resume_pulse(resume_pulse), .int_req(int_req));

  // =====================================================================
  // Helpers.
  function automatic [31:0] xs(input [31:0] s);
    reg [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  function automatic [31:0] csw(input [5:0] c, input g);
    csw = {16'h0000, c, 9'h000, g};
  endfunction
  task tick(input integer m);
    repeat (m) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask
  task rd(input [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    rd_d = reg_rdata;
    tick(1);
  endtask
  task fire(input [3:0] l);
    int_line <= l;
    int_go <= 1'b1;
    tick(1);
    int_go <= 1'b0;
  endtask
  task end_sim;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Ceiling well above the few hundred cycles the sequence needs.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      end_sim;
    end
  end

  // =====================================================================
  // Main sequence.
  initial begin
    {rst_n, reg_wr, reg_rd, int_go, int_clr, emu_present} = 6'h00;
    {emu_reset, emu_exec_req, emu_pc_write} = 3'h0;
    {reg_addr, int_line, reg_wdata, cyc, num_errors, cmp_count} = 0;
    seed = 32'h0000_0057;
    code_t = '{`PDML_PDS_LS_EN, `PDML_PDS_LS_EN, `PDML_PDS_LS_ANY, 6'h00};
    isr_t = '{2'h3, 2'h0, 2'h2};
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    `CHK(cpu_clk_en, 1'b0)
    tick(LOCK + 3);
    rd(`PDML_OFS_CSW);
    `CHK(rd_d, `PDML_CSW_RST)
    rd(`PDML_OFS_IER);
    `CHK(rd_d, `PDML_IER_RST)
    rd(4'hF);
    `CHK(rd_d, 32'h0000_0000)
    // Light sleep: bit 1 of isr_t is GLOBAL_INT_ENABLE, bit 0 the expected service.
    for (i = 0; i < 3; i++) begin
      wr(`PDML_OFS_CSW, 32'h0000_0000);
      tick(12);
      seed = xs(seed);
      k = 2 + seed % 14;
      int_enable_reg = (seed[31:16] | 16'h0002) & 16'hFFFE;
      int_enable_reg[k] = (i != 2);
      wr(`PDML_OFS_IER, {16'h0000, int_enable_reg});
      wr(`PDML_OFS_CSW, csw(code_t[i], isr_t[i][1]));
      for (n = 0; n < 10 && pd_state !== 2'h1; n++) tick(1);
      `CHK(pd_state, 2'h1)
      `CHK({cpu_clk_en, run_ok, ilc_en, dma_en}, 4'h3)
      rd(`PDML_OFS_STAT);
      `CHK(rd_d, {27'h0, 2'b01, i == 2, 2'h1})
      if (i < 2) begin
        fire(4'h0);
        tick(5);
        `CHK(pd_state, 2'h1)
        int_clr <= 1'b1;
        tick(1);
        int_clr <= 1'b0;
      end
      fire(k[3:0]);
      for (n = 0; n < 10 && resume_pulse !== 1'b1; n++) tick(1);
      `CHK(resume_pulse, 1'b1)
      `CHK(isr_start, isr_t[i][0])
    end
    code_t = '{6'h01, 6'h08, 6'h1B, 6'h1F};
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(`PDML_OFS_CSW, csw(code_t[i], 1'b0) | (seed & 32'hFFFF_03FE));
      tick(12);
      `CHK({pd_state, cpu_clk_en}, 3'h1)
      rd(`PDML_OFS_CSW);
      `CHK(rd_d, csw(code_t[i], 1'b0))
    end
    emu_present <= 1'b1;
    tick(4);
    wr(`PDML_OFS_CSW, csw(`PDML_PDS_HALT, 1'b0));
    tick(12);
    `CHK(pd_state, 2'h0)
    code_t = '{`PDML_PDS_HALT, `PDML_PDS_PLLSTOP, 6'h00, 6'h00};
    for (i = 0; i < 2; i++) begin
      emu_reset <= (i == 1);
      emu_present <= (i == 1);
      tick(4);
      wr(`PDML_OFS_CSW, 32'h0000_0000);
      tick(12);
      wr(`PDML_OFS_CSW, csw(code_t[i], 1'b1));
      for (n = 0; n < 10 && pd_state !== 2 + i; n++) tick(1);
      `CHK(pd_state, 2'h2 + i)
      `CHK({pll_en, ref_en}, 2'h1 + i)
      `CHK({io_hold, ext_p, cpu_clk_en, ilc_en, dma_en}, 5'h18)
      fire(4'h3);
      emu_exec_req <= 1'b1;
      emu_pc_write <= 1'b1;
      tick(20);
      `CHK(pd_state, 2'h2 + i)
      `CHK({exec_ack, pcw_ok}, 2'h0)
      rd(`PDML_OFS_CSW);
      `CHK(rd_d, csw(code_t[i], 1'b1))
      rst_n <= 1'b0;
      tick(2);
      rst_n <= 1'b1;
      tick(1);
      `CHK({pd_state, cpu_clk_en}, 3'h0)
      tick(LOCK + 3);
      `CHK({cpu_clk_en, run_ok, exec_ack, pcw_ok}, 4'hF)
      emu_exec_req <= 1'b0;
      emu_pc_write <= 1'b0;
    end
    end_sim;
  end
endmodule
